//--- hw/esfr_pkg.sv
// Notes on behaviour
// - tx DMA bus error sets bit 14
// - rx DMA bus error sets bit 13
// - sticky flags clear by reset or clear alias
// - empty mark set when count at/below level
// - empty mark cleared by hardware count increment
// - full mark set when count at/above level
// - full mark cleared by buffer decrement write
// - software writes other than the buffer decrement write never alter watermark flags
// - receive done sets bit 7
// - link fail shows last PHY status read
// - bit 2 high while management read pending
// - bit 1 high while scan in progress
// - bit 0 high while management cycle busy
// - 16/32-bit accesses taken, 8-bit ignored
// - octet four bits 15-8, three bits 7-0
// - station address loads factory value on the first edge after reset release
// - indicator bits 31-4 read zero
`default_nettype none

package esfr_pkg;

   localparam int ADDR_W = 8;

   localparam logic [7:0] OFS_IRQ = 8'h00;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h04;
   localparam logic [7:0] OFS_IRQ_SET = 8'h08;
   localparam logic [7:0] OFS_IRQ_INV = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OFS_MIND = 8'h14;
   localparam logic [7:0] OFS_SA1 = 8'h18;
   localparam logic [7:0] OFS_SA1_CLR = 8'h1C;
   localparam logic [7:0] OFS_SA1_SET = 8'h20;
   localparam logic [7:0] OFS_SA1_INV = 8'h24;
   localparam logic [7:0] OFS_CON1 = 8'h28;

   localparam int BIT_TX_BUS_ERR = 14;
   localparam int BIT_RX_BUS_ERR = 13;
   localparam int BIT_EMPTY_MARK = 9;
   localparam int BIT_FULL_MARK = 8;
   localparam int BIT_RX_DONE = 7;
   localparam int BIT_BUF_DEC = 0;
   localparam int NSTICKY = 3;
   // index 0 receive done, 1 rx bus error, 2 tx bus error
   localparam int STICKY_POS [0:2] = '{7, 13, 14};

   localparam int OCTET_W = 8;
   localparam int SA_W = 16;
   localparam int MIND_W = 4;

   localparam logic [31:0] IRQ_MASK = 32'h0000_6380;
   localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
   localparam logic [15:0] SA1_RST = 16'h0000;
   localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

   localparam logic [3:0] STRB_HALF_LO = 4'h3;
   localparam logic [3:0] STRB_HALF_HI = 4'hC;
   localparam logic [3:0] STRB_WORD = 4'hF;

endpackage

`default_nettype wire

//--- hw/esfr_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

module esfr_sticky_flag (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hwSet,
   input wire logic swSet,
   input wire logic swClr,
   output logic flag
);

   logic flag_q;
   logic flag_d;

   // software may only clear through the clear alias; a hardware event in
   // the same cycle still wins so no error is lost
   always_comb begin
      flag_d = flag_q;
      if (swClr) begin
         flag_d = 1'b0;
      end
      if (swSet | hwSet) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule // esfr_sticky_flag

`default_nettype wire

//--- hw/esfr_mark_flag.sv
`timescale 1ns/1ps
`default_nettype none

module esfr_mark_flag (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reached,
   input wire logic clrEvent,
   output logic flag
);

   logic flag_q;

   // the count still shows its old value in the clearing cycle, so the
   // clear must win here or the flag could never drop; the level re-arms
   // it one cycle later if the count is still past the mark
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (clrEvent) begin
         flag_q <= 1'b0;
      end else if (reached) begin
         flag_q <= 1'b1;
      end
   end

   assign flag = flag_q;

endmodule // esfr_mark_flag

`default_nettype wire

//--- hw/esfr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module esfr_regs (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [esfr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic txBusError,
   input wire logic rxBusError,
   input wire logic rxPacketDone,
   input wire logic [7:0] rxBufCount,
   input wire logic [7:0] emptyLevel,
   input wire logic [7:0] fullLevel,
   input wire logic bufCountInc,
   output logic bufCountDec,
   input wire logic phyReadDone,
   input wire logic phyLinkFail,
   input wire logic mgmtReadPending,
   input wire logic mgmtScanning,
   input wire logic mgmtBusy,
   input wire logic [15:0] factoryAddr,
   output logic [15:0] stationAddr,
   output logic irq
);

   localparam int NSTICKY = esfr_pkg::NSTICKY;

   logic setupPh;
   logic accessPh;
   logic strbOk;
   logic mapped;
   logic wrOk;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic hitIrq;
   logic hitIrqClr;
   logic hitIrqSet;
   logic hitIrqInv;
   logic hitAnyIrq;
   logic hitEn;
   logic hitMind;
   logic hitSa;
   logic hitSaClr;
   logic hitSaSet;
   logic hitSaInv;
   logic hitCon1;
   logic [NSTICKY-1:0] stickyHw;
   logic [NSTICKY-1:0] stickySet;
   logic [NSTICKY-1:0] stickyClr;
   logic [NSTICKY-1:0] stickyFlag;
   logic emptyReached;
   logic fullReached;
   logic emptyFlag;
   logic fullFlag;
   logic [31:0] irqFlags;
   logic [31:0] irqEn_q;
   logic [15:0] sa_q;
   logic [15:0] sa_d;
   logic saLoad_q;
   logic bufDec_q;
   logic link_fail_indicator_q;
   logic [31:0] mindVal;
   logic [31:0] readMux;
   logic [31:0] prdata_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // ---------------- bus decode
   assign setupPh = psel & ~penable;
   assign accessPh = psel & penable;

   assign hitIrq = (paddr == esfr_pkg::OFS_IRQ);
   assign hitIrqClr = (paddr == esfr_pkg::OFS_IRQ_CLR);
   assign hitIrqSet = (paddr == esfr_pkg::OFS_IRQ_SET);
   assign hitIrqInv = (paddr == esfr_pkg::OFS_IRQ_INV);
   assign hitEn = (paddr == esfr_pkg::OFS_IRQ_EN);
   assign hitMind = (paddr == esfr_pkg::OFS_MIND);
   assign hitSa = (paddr == esfr_pkg::OFS_SA1);
   assign hitSaClr = (paddr == esfr_pkg::OFS_SA1_CLR);
   assign hitSaSet = (paddr == esfr_pkg::OFS_SA1_SET);
   assign hitSaInv = (paddr == esfr_pkg::OFS_SA1_INV);
   assign hitCon1 = (paddr == esfr_pkg::OFS_CON1);
   assign hitAnyIrq = hitIrq | hitIrqClr | hitIrqSet | hitIrqInv;

   assign mapped = hitAnyIrq | hitEn | hitMind | hitSa | hitSaClr
      | hitSaSet | hitSaInv | hitCon1;

   // a lone byte lane or a scattered lane pattern is a byte access
   assign strbOk = (pstrb == esfr_pkg::STRB_WORD)
      | (pstrb == esfr_pkg::STRB_HALF_LO)
      | (pstrb == esfr_pkg::STRB_HALF_HI);

   assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
      {8{pstrb[0]}}};
   assign wbits = pwdata & wmask;
   assign wrOk = accessPh & pwrite & strbOk & mapped;

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = accessPh & ~mapped;

   // ---------------- sticky interrupt flags
   assign stickyHw = {txBusError, rxBusError, rxPacketDone};

   genvar gi;
   generate
      for (gi = 0; gi < NSTICKY; gi++) begin : gSticky
         // direct, set and invert writes only ever force a flag on,
         // leaving the clear alias as the single way to drop it
         assign stickySet[gi] = wrOk & (hitIrq | hitIrqSet | hitIrqInv)
            & wbits[esfr_pkg::STICKY_POS[gi]];
         assign stickyClr[gi] = wrOk & hitIrqClr
            & wbits[esfr_pkg::STICKY_POS[gi]];
         esfr_sticky_flag uFlag (
            .clk(clk),
            .arst_n(arst_n),
            .hwSet(stickyHw[gi]),
            .swSet(stickySet[gi]),
            .swClr(stickyClr[gi]),
            .flag(stickyFlag[gi])
         );
      end
   endgenerate

   // ---------------- watermark flags, only the full flag reached by software, through the decrement write
   assign emptyReached = (rxBufCount <= emptyLevel);
   assign fullReached = (rxBufCount >= fullLevel);

   esfr_mark_flag uEmpty (
      .clk(clk),
      .arst_n(arst_n),
      .reached(emptyReached),
      .clrEvent(bufCountInc),
      .flag(emptyFlag)
   );

   esfr_mark_flag uFull (
      .clk(clk),
      .arst_n(arst_n),
      .reached(fullReached),
      .clrEvent(bufDec_q),
      .flag(fullFlag)
   );

   always_comb begin
      irqFlags = 32'h0000_0000;
      irqFlags[esfr_pkg::BIT_TX_BUS_ERR] = stickyFlag[2];
      irqFlags[esfr_pkg::BIT_RX_BUS_ERR] = stickyFlag[1];
      irqFlags[esfr_pkg::BIT_EMPTY_MARK] = emptyFlag;
      irqFlags[esfr_pkg::BIT_FULL_MARK] = fullFlag;
      irqFlags[esfr_pkg::BIT_RX_DONE] = stickyFlag[0];
   end

   // ---------------- interrupt enable and output
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqEn_q <= esfr_pkg::IRQ_EN_RST;
      end else if (wrOk & hitEn) begin
         irqEn_q <= ((irqEn_q & ~wmask) | wbits) & esfr_pkg::IRQ_MASK;
      end
   end

   assign irq = |(irqFlags & irqEn_q);

   // ---------------- buffer decrement strobe
   // registered so the counter outside and the full flag see one edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bufDec_q <= 1'b0;
      end else begin
         bufDec_q <= wrOk & hitCon1 & wbits[esfr_pkg::BIT_BUF_DEC];
      end
   end

   assign bufCountDec = bufDec_q;

   // ---------------- management indicators
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         link_fail_indicator_q <= 1'b0;
      end else if (phyReadDone) begin
         link_fail_indicator_q <= phyLinkFail;
      end
   end

   // indicators follow the management unit; writes to them are dropped
   assign mindVal = {28'h0000000, link_fail_indicator_q, mgmtReadPending,
      mgmtScanning, mgmtBusy};

   // ---------------- station address
   // the factory value is a port, so it is taken on the first edge after
   // reset release rather than by the asynchronous reset itself
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         saLoad_q <= 1'b1;
      end else begin
         saLoad_q <= 1'b0;
      end
   end

   always_comb begin
      sa_d = sa_q;
      if (wrOk & hitSa) begin
         sa_d = (sa_q & ~wmask[15:0]) | wbits[15:0];
      end else if (wrOk & hitSaClr) begin
         sa_d = sa_q & ~wbits[15:0];
      end else if (wrOk & hitSaSet) begin
         sa_d = sa_q | wbits[15:0];
      end else if (wrOk & hitSaInv) begin
         sa_d = sa_q ^ wbits[15:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sa_q <= esfr_pkg::SA1_RST;
      end else if (saLoad_q) begin
         sa_q <= factoryAddr;
      end else begin
         sa_q <= sa_d;
      end
   end

   // octet four high, octet three low
   assign stationAddr = sa_q;

   // ---------------- read data
   always_comb begin
      case (paddr)
         esfr_pkg::OFS_IRQ: readMux = irqFlags;
         esfr_pkg::OFS_IRQ_EN: readMux = irqEn_q;
         esfr_pkg::OFS_MIND: readMux = mindVal;
         esfr_pkg::OFS_SA1: readMux = {16'h0000, sa_q};
         default: readMux = 32'h0000_0000;
      endcase
   end

   // captured in the setup cycle so the access cycle can complete at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= esfr_pkg::PRDATA_RST;
      end else if (setupPh & ~pwrite) begin
         prdata_q <= readMux;
      end
   end

   assign prdata = prdata_q;

   // ---------------- checks
   sequence mindReadSeq;
      setupPh && !pwrite && hitMind;
   endsequence

   sequence quietIrqWrite;
      wrOk && hitAnyIrq && !bufCountInc && !bufDec_q
         && !emptyReached && !fullReached;
   endsequence

   txErrSet_a: assert property (txBusError |=> stickyFlag[2])
      else $error("tx bus error flag not raised");

   rxErrSet_a: assert property (rxBusError |=> stickyFlag[1])
      else $error("rx bus error flag not raised");

   stickyHold_a: assert property (
      ((~stickyFlag) & $past(stickyFlag) & ~$past(stickyClr))
         == {NSTICKY{1'b0}})
      else $error("sticky flag dropped without clear write");

   emptySet_a: assert property (
      emptyReached && !bufCountInc |=> emptyFlag)
      else $error("empty mark not raised");

   emptyClr_a: assert property (
      $fell(emptyFlag) |-> $past(bufCountInc))
      else $error("empty mark dropped without count increment");

   fullSet_a: assert property (fullReached && !bufDec_q |=> fullFlag)
      else $error("full mark not raised");

   fullClr_a: assert property (
      (wrOk && hitCon1 && wbits[0]) |=> bufDec_q ##1 !fullFlag)
      else $error("decrement write did not clear full mark");

   markWrite_a: assert property (
      quietIrqWrite |=> $stable({emptyFlag, fullFlag}))
      else $error("software write altered a watermark flag");

   rxDoneSet_a: assert property (rxPacketDone |=> stickyFlag[0])
      else $error("receive done flag not raised");

   linkCapture_a: assert property (
      phyReadDone |=> link_fail_indicator_q == $past(phyLinkFail))
      else $error("link fail not captured from phy read");

   mindRead_a: assert property (mindReadSeq |=> prdata ==
      {28'h0000000, $past(link_fail_indicator_q), $past(mgmtReadPending),
       $past(mgmtScanning), $past(mgmtBusy)})
      else $error("indicator read data wrong");

   byteIgnore_a: assert property (
      (accessPh && pwrite && !strbOk && !saLoad_q)
         |=> $stable(irqEn_q) && $stable(sa_q) && !bufDec_q)
      else $error("byte write was not ignored");

   saOctet_a: assert property (
      (wrOk && hitSa && pstrb == esfr_pkg::STRB_WORD && !saLoad_q)
         |=> stationAddr[15:8] == $past(pwdata[15:8])
            && stationAddr[7:0] == $past(pwdata[7:0]))
      else $error("station octets misplaced");

   saLoad_a: assert property (
      saLoad_q |=> stationAddr == $past(factoryAddr))
      else $error("factory station address not loaded");

   // alias clear of receive done with no packet event in the same cycle
   sequence doneClrSeq;
      stickyClr[0] && !rxPacketDone;
   endsequence

   doneClr_a: assert property (doneClrSeq |=> !stickyFlag[0])
      else $error("receive done flag not cleared by alias write");

   emptyDrop_a: assert property (bufCountInc |=> !emptyFlag)
      else $error("empty mark kept after count increment");

   mindZero_a: assert property (
      mindReadSeq |=> prdata[31:4] == 28'h0000000)
      else $error("indicator upper bits not zero");

   // the upper half of the station word is unimplemented
   halfWrite_a: assert property (
      (wrOk && hitSa && pstrb == esfr_pkg::STRB_HALF_HI && !saLoad_q)
         |=> stationAddr == $past(sa_q))
      else $error("upper half write altered station octets");

endmodule // esfr_regs

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin fails++; \
$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, rxBufCount, emptyLevel, fullLevel, lvl;
   logic [31:0] pwdata, prdata, rdData, en, clr;
   logic [3:0] pstrb, m;
   logic txBusError, rxBusError, rxPacketDone, bufCountInc, bufCountDec;
   logic phyReadDone, phyLinkFail, mgmtReadPending, mgmtScanning, mgmtBusy;
   logic [15:0] factoryAddr, stationAddr, sa;
   logic [2:0] st, ev;
   logic slvErr;
   int fails, nChecks, cyc, i;

   esfr_regs esfr_regs_i (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .txBusError(txBusError), .rxBusError(rxBusError),
      .rxPacketDone(rxPacketDone), .rxBufCount(rxBufCount),
      .emptyLevel(emptyLevel), .fullLevel(fullLevel),
      .bufCountInc(bufCountInc), .bufCountDec(bufCountDec),
      .phyReadDone(phyReadDone), .phyLinkFail(phyLinkFail),
      .mgmtReadPending(mgmtReadPending), .mgmtScanning(mgmtScanning),
      .mgmtBusy(mgmtBusy), .factoryAddr(factoryAddr),
      .stationAddr(stationAddr), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end

   // one APB transfer; the request stands until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // only the bench timeout ends a wait that never sees pready
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdData = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] irqWord(input logic [2:0] s,
                                           input logic em, input logic fm);
      irqWord = 32'h0;
      irqWord[14] = s[2];
      irqWord[13] = s[1];
      irqWord[9] = em;
      irqWord[8] = fm;
      irqWord[7] = s[0];
   endfunction

   initial begin
      void'($urandom(32'h8D38F245));
      {psel, penable, pwrite, txBusError, rxBusError, rxPacketDone} = '0;
      {bufCountInc, phyReadDone, phyLinkFail} = '0;
      {mgmtReadPending, mgmtScanning, mgmtBusy} = '0;
      {paddr, pwdata, pstrb} = '0;
      rxBufCount = 8'h80;
      emptyLevel = 8'h00;
      fullLevel = 8'hFF;
      factoryAddr = 16'($urandom);
      arst_n = 1'b0;
      fails = 0;
      nChecks = 0;
      cyc = 0;
      st = 3'h0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(stationAddr, factoryAddr)
      apb(1'b0, esfr_pkg::OFS_SA1, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, {16'h0, factoryAddr})
      sa = 16'($urandom);
      apb(1'b1, esfr_pkg::OFS_SA1, {16'hFFFF, sa}, esfr_pkg::STRB_HALF_LO);
      apb(1'b1, esfr_pkg::OFS_SA1, ~32'h0, 4'h1);
      apb(1'b0, esfr_pkg::OFS_SA1, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, {16'h0, sa})
      `CHK(stationAddr, sa)
      apb(1'b1, esfr_pkg::OFS_SA1, ~32'h0, esfr_pkg::STRB_HALF_HI);
      #1 `CHK(stationAddr, sa)
      apb(1'b1, esfr_pkg::OFS_SA1_SET, 32'h00F0, esfr_pkg::STRB_WORD);
      apb(1'b1, esfr_pkg::OFS_SA1_CLR, 32'h0F00, esfr_pkg::STRB_WORD);
      apb(1'b1, esfr_pkg::OFS_SA1_INV, 32'h8001, esfr_pkg::STRB_HALF_LO);
      #1 `CHK(stationAddr, ((sa | 16'h00F0) & ~16'h0F00) ^ 16'h8001)
      // sticky events, random subsets, cleared only through the alias
      for (i = 0; i < 8; i++) begin
         ev = (i == 0) ? 3'h7 : 3'($urandom);
         @(posedge clk);
         {txBusError, rxBusError, rxPacketDone} <= ev;
         @(posedge clk);
         {txBusError, rxBusError, rxPacketDone} <= 3'h0;
         st = st | ev;
         apb(1'b1, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
         apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
         `CHK(rdData, irqWord(st, 1'b0, 1'b0))
         en = $urandom & esfr_pkg::IRQ_MASK;
         apb(1'b1, esfr_pkg::OFS_IRQ_EN, en | 32'hFFFF_0000,
             esfr_pkg::STRB_WORD);
         #1 `CHK(irq, |(irqWord(st, 1'b0, 1'b0) & en))
         apb(1'b0, esfr_pkg::OFS_IRQ_EN, 32'h0, esfr_pkg::STRB_WORD);
         `CHK(rdData, en)
         clr = $urandom;
         apb(1'b1, esfr_pkg::OFS_IRQ_CLR, clr, (i == 1) ? 4'h1 : 4'hF);
         if (i != 1) st = st & ~{clr[14], clr[13], clr[7]};
         apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
         `CHK(rdData, irqWord(st, 1'b0, 1'b0))
      end
      // set alias and invert alias can only raise the sticky flags
      apb(1'b1, esfr_pkg::OFS_IRQ_SET, 32'h0000_4000, esfr_pkg::STRB_WORD);
      apb(1'b1, esfr_pkg::OFS_IRQ_INV, 32'h0000_6080, esfr_pkg::STRB_WORD);
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, irqWord(3'h7, 1'b0, 1'b0))
      apb(1'b1, esfr_pkg::OFS_IRQ_CLR, 32'h6080, esfr_pkg::STRB_WORD);
      // empty mark at the boundary count == level
      lvl = 8'($urandom_range(10, 200));
      rxBufCount <= lvl;
      emptyLevel <= lvl;
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, irqWord(3'h0, 1'b1, 1'b0))
      // count leaves the mark first, so only a write could drop the flag
      rxBufCount <= lvl + 8'h1;
      apb(1'b1, esfr_pkg::OFS_IRQ_CLR, 32'h300, esfr_pkg::STRB_WORD);
      apb(1'b1, esfr_pkg::OFS_IRQ, 32'h300, esfr_pkg::STRB_WORD);
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, irqWord(3'h0, 1'b1, 1'b0))
      @(posedge clk);
      bufCountInc <= 1'b1;
      @(posedge clk);
      bufCountInc <= 1'b0;
      emptyLevel <= 8'h00;
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, 32'h0)
      // full mark at the boundary, cleared by the decrement write
      fullLevel <= lvl;
      rxBufCount <= lvl;
      apb(1'b1, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, irqWord(3'h0, 1'b0, 1'b1))
      rxBufCount <= lvl - 8'h1;
      apb(1'b1, esfr_pkg::OFS_CON1, 32'h1, esfr_pkg::STRB_WORD);
      #1 `CHK(bufCountDec, 1'b1)
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, 32'h0)
      `CHK(bufCountDec, 1'b0)
      // indicators; link fail is taken only with the read strobe
      for (i = 0; i < 6; i++) begin
         m = 4'($urandom);
         @(posedge clk);
         {phyLinkFail, mgmtReadPending, mgmtScanning, mgmtBusy} <= m;
         phyReadDone <= 1'b1;
         @(posedge clk);
         phyReadDone <= 1'b0;
         phyLinkFail <= ~m[3];
         apb(1'b0, esfr_pkg::OFS_MIND, 32'h0, esfr_pkg::STRB_WORD);
         `CHK(rdData, {28'h0, m})
      end
      // mid-run reset drops the sticky flags and reloads the station address
      @(posedge clk);
      {txBusError, rxBusError, rxPacketDone} <= 3'h7;
      @(posedge clk);
      {txBusError, rxBusError, rxPacketDone} <= 3'h0;
      factoryAddr <= 16'($urandom);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(stationAddr, factoryAddr)
      apb(1'b0, esfr_pkg::OFS_IRQ, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(rdData, 32'h0)
      apb(1'b0, 8'h2C, 32'h0, esfr_pkg::STRB_WORD);
      `CHK(slvErr, 1'b1)
      `CHK(rdData, 32'h0)
      complete_run();
   end
endmodule // tb

`default_nettype wire
